/* File: logic/lrfp_pkg.sv */
// Package: register map, field positions and constants for fault policy
package lrfp_pkg;
  // Byte addresses on the register bus
  localparam logic [7:0] LRFP_ADDR_CFG = 8'h00; // Policy config word
  localparam logic [7:0] LRFP_ADDR_SOURCES = 8'h04; // Recovery thresholds
  localparam logic [7:0] LRFP_ADDR_STATUS = 8'h08; // Sticky event bits
  localparam logic [7:0] LRFP_ADDR_MASK = 8'h0C; // Interrupt mask
  localparam logic [7:0] LRFP_ADDR_CMD = 8'h10; // Host clear commands
  localparam logic [7:0] LRFP_ADDR_STATE = 8'h14; // Live state
  localparam logic [7:0] LRFP_ADDR_SC_TIME = 8'h18; // Short recovery cycles
  localparam logic [7:0] LRFP_ADDR_OC_TIME = 8'h1C; // Overcurrent cycles
  localparam logic [7:0] LRFP_ADDR_FUSE_MIN = 8'h20; // Fuse minimum voltage
  // Configuration word
  localparam logic [15:0] LRFP_CFG_RESET = 16'h0002;
  localparam logic [15:0] LRFP_CFG_WMASK = 16'h07FF; // Bits 15..11 read zero
  localparam int LRFP_BIT_SC_REC = 10;
  localparam int LRFP_BIT_OC_REC = 9;
  localparam int LRFP_BIT_FET_BYPASS = 8;
  localparam int LRFP_BIT_PACK_SEL = 7;
  localparam int LRFP_BIT_PF_BLOW = 4;
  // Recovery threshold register: short low half, overcurrent high half
  localparam logic [31:0] LRFP_SOURCES_RESET = 32'h0000_0000;
  localparam logic [31:0] LRFP_TIME_RESET = 32'h0000_0064;
  localparam logic [15:0] LRFP_FUSE_MIN_RESET = 16'h0000;
  // Status and command bit positions
  localparam int LRFP_EV_SC_CLR = 0; // Short latch recovered
  localparam int LRFP_EV_OC_CLR = 1; // Overcurrent latch recovered
  localparam int LRFP_EV_FUSE = 2; // Fuse blow attempted
  localparam int LRFP_NEV = 3;
  localparam logic [31:0] LRFP_ZERO = 32'h0000_0000;
  // Bus encodings
  localparam logic [1:0] LRFP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LRFP_HTRANS_SEQ = 2'h3;
endpackage

/* File: logic/lrfp_recover_timer.sv */
// Sustained current qualifier for one latched fault
`timescale 1ns/10ps
module lrfp_recover_timer
  import lrfp_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic latched, // Fault currently latched
  input wire logic enable, // Current recovery allowed
  input wire logic signed [15:0] current, // Measured current
  input wire logic signed [15:0] threshold, // Recovery threshold
  input wire logic [31:0] hold_cycles, // Recovery time in cycles
  output logic expire // One-cycle recover pulse
);
  logic [31:0] count_ff; // Cycles spent above threshold
  logic [31:0] nxt_count;
  logic nxt_expire;
  logic expire_ff;
  logic above;

  // Qualify and count; any dip restarts from zero
  always_comb begin
    above = (current >= threshold);
    nxt_count = LRFP_ZERO;
    nxt_expire = 1'b0;
    if (latched && enable && above && !expire_ff) begin
      if (count_ff + 32'h0000_0001 >= hold_cycles) begin
        nxt_expire = 1'b1;
      end else begin
        nxt_count = count_ff + 32'h0000_0001;
      end
    end
  end

  // Register the counter and pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= 32'h0000_0000;
      expire_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expire_ff <= nxt_expire;
    end
  end

  assign expire = expire_ff;

  // Counter resets whenever current drops below threshold
  chk_dip_restarts: assert property (@(posedge hclk) disable iff (!hresetn)
    !above |=> count_ff == 32'h0000_0000)
    else $error("recovery count not restarted after dip");
endmodule

/* File: logic/lrfp_top.sv */
// Latched-fault recovery and fuse-blow policy with AHB-Lite registers
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - 16-bit config, reset 0x0002, top five zero
// - short latch clears by load, host, current
// - bit 10 enables sustained-current short recovery
// - overcurrent latch clears by load, host, current
// - bit 9 enables sustained-current overcurrent recovery
// - fuse blow needs voltage above minimum
// - bit 8 bypasses voltage on switch failure
// - without bit 8 switch failure needs voltage
// - bit 7 picks pack or stack voltage
// - bit 4 enables fuse blow on failure
module lrfp_top
  import lrfp_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  input wire logic short_circuit_discharge, // Short fault trip pulse
  input wire logic overcurrent_discharge, // Overcurrent trip pulse
  input wire logic load_sense_pin, // High when load removed
  input wire logic signed [15:0] current, // Current, same clock
  input wire logic signed [15:0] stack_voltage, // Top of stack voltage
  input wire logic signed [15:0] pack_voltage, // Pack pin voltage
  input wire logic permanent_failure, // Any permanent failure
  input wire logic charge_switch_failure, // Charge switch failed
  input wire logic discharge_switch_failure, // Discharge switch failed
  output logic short_circuit_latched_fault, // Short latch state
  output logic discharge_overcurrent_latched_fault, // OC latch state
  output logic fuse_blow, // Fuse blow request level
  output logic irq // Level interrupt
);
  // Registers
  logic [15:0] cfg_ff; // Policy configuration
  logic [31:0] thr_ff; // Recovery thresholds
  logic [31:0] sc_time_ff; // Short recovery time
  logic [31:0] oc_time_ff; // OC recovery time
  logic [15:0] fuse_min_ff; // Minimum fuse voltage
  logic [LRFP_NEV-1:0] stat_ff; // Sticky events
  logic [LRFP_NEV-1:0] mask_ff; // Interrupt enables
  logic [15:0] nxt_cfg;
  logic [31:0] nxt_thr;
  logic [31:0] nxt_sc_time;
  logic [31:0] nxt_oc_time;
  logic [15:0] nxt_fuse_min;
  logic [LRFP_NEV-1:0] nxt_stat;
  logic [LRFP_NEV-1:0] nxt_mask;
  logic [LRFP_NEV-1:0] w1c_stat; // Status after host write-one clear
  // Bus data phase capture
  logic wr_pend_ff; // Write data phase pending
  logic [7:0] wr_addr_ff; // Captured write address
  logic [31:0] rdata_ff;
  logic nxt_wr_pend;
  logic [7:0] nxt_wr_addr;
  logic [31:0] nxt_rdata;
  // Policy state
  logic sc_lat_ff;
  logic oc_lat_ff;
  logic fuse_ff;
  logic irq_ff;
  logic nxt_sc_lat;
  logic nxt_oc_lat;
  logic nxt_fuse;
  logic nxt_irq;
  // Load sense synchroniser, three stages
  logic [2:0] ld_sync_ff;
  logic [2:0] nxt_ld_sync;
  logic ld_removed_ff; // Filtered load-removed level
  logic nxt_ld_removed;
  // Internal
  logic sc_cur_rec;
  logic oc_cur_rec;
  logic cmd_sc;
  logic cmd_oc;
  logic volt_ok;
  logic blow_req;
  logic signed [15:0] sel_volt;
  logic acc;

  // Decode a valid transfer address phase
  function automatic logic lrfp_take(input logic s, input logic [1:0] t,
                                     input logic r);
    lrfp_take = s && r && (t == LRFP_HTRANS_NONSEQ || t == LRFP_HTRANS_SEQ);
  endfunction

  // Short latch current qualifier
  lrfp_recover_timer u_sc_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .latched(sc_lat_ff),
    .enable(cfg_ff[LRFP_BIT_SC_REC]),
    .current(current),
    .threshold(thr_ff[15:0]),
    .hold_cycles(sc_time_ff),
    .expire(sc_cur_rec)
  );

  // Overcurrent latch current qualifier
  lrfp_recover_timer u_oc_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .latched(oc_lat_ff),
    .enable(cfg_ff[LRFP_BIT_OC_REC]),
    .current(current),
    .threshold(thr_ff[31:16]),
    .hold_cycles(oc_time_ff),
    .expire(oc_cur_rec)
  );

  // Bus and register next state; zero-wait slave
  always_comb begin
    acc = lrfp_take(hsel, htrans, hready);
    nxt_wr_pend = acc && hwrite;
    nxt_wr_addr = haddr[7:0];
    nxt_rdata = LRFP_ZERO;
    nxt_cfg = cfg_ff;
    nxt_thr = thr_ff;
    nxt_sc_time = sc_time_ff;
    nxt_oc_time = oc_time_ff;
    nxt_fuse_min = fuse_min_ff;
    nxt_mask = mask_ff;
    cmd_sc = 1'b0;
    cmd_oc = 1'b0;
    w1c_stat = stat_ff;
    if (acc && !hwrite) begin
      // Read data for the next data phase; unmapped reads as zero
      case (haddr[7:0])
        LRFP_ADDR_CFG: nxt_rdata = {16'h0000, cfg_ff};
        LRFP_ADDR_SOURCES: nxt_rdata = thr_ff;
        LRFP_ADDR_STATUS: nxt_rdata = {29'h0000_0000, stat_ff};
        LRFP_ADDR_MASK: nxt_rdata = {29'h0000_0000, mask_ff};
        LRFP_ADDR_STATE: nxt_rdata = {29'h0000_0000, fuse_ff,
                                      oc_lat_ff, sc_lat_ff};
        LRFP_ADDR_SC_TIME: nxt_rdata = sc_time_ff;
        LRFP_ADDR_OC_TIME: nxt_rdata = oc_time_ff;
        LRFP_ADDR_FUSE_MIN: nxt_rdata = {16'h0000, fuse_min_ff};
        default: nxt_rdata = LRFP_ZERO;
      endcase
    end
    if (wr_pend_ff) begin
      // Writes land in the data phase
      case (wr_addr_ff)
        LRFP_ADDR_CFG: nxt_cfg = hwdata[15:0] & LRFP_CFG_WMASK;
        LRFP_ADDR_SOURCES: nxt_thr = hwdata;
        LRFP_ADDR_STATUS: w1c_stat = stat_ff & ~hwdata[LRFP_NEV-1:0];
        LRFP_ADDR_MASK: nxt_mask = hwdata[LRFP_NEV-1:0];
        LRFP_ADDR_CMD: begin
          cmd_sc = hwdata[LRFP_EV_SC_CLR];
          cmd_oc = hwdata[LRFP_EV_OC_CLR];
        end
        LRFP_ADDR_SC_TIME: nxt_sc_time = hwdata;
        LRFP_ADDR_OC_TIME: nxt_oc_time = hwdata;
        LRFP_ADDR_FUSE_MIN: nxt_fuse_min = hwdata[15:0];
        default: nxt_cfg = cfg_ff;
      endcase
    end
  end

  // Load sense sampled through three flops; change when last two agree
  always_comb begin
    nxt_ld_sync = {ld_sync_ff[1:0], load_sense_pin};
    nxt_ld_removed = ld_removed_ff;
    if (ld_sync_ff[1] == ld_sync_ff[2]) begin
      nxt_ld_removed = ld_sync_ff[2];
    end
  end

  // Fault latches, fuse policy and event bits
  always_comb begin
    // Start from the cleared view; events below set on top of it
    nxt_stat = w1c_stat;
    nxt_sc_lat = sc_lat_ff;
    nxt_oc_lat = oc_lat_ff;
    // Any of three routes clears the latch
    if (ld_removed_ff || cmd_sc || sc_cur_rec) begin
      nxt_sc_lat = 1'b0;
    end
    if (ld_removed_ff || cmd_oc || oc_cur_rec) begin
      nxt_oc_lat = 1'b0;
    end
    // A new trip beats a simultaneous recovery
    if (short_circuit_discharge) begin
      nxt_sc_lat = 1'b1;
    end
    if (overcurrent_discharge) begin
      nxt_oc_lat = 1'b1;
    end
    // Pack or stack voltage against the minimum
    sel_volt = cfg_ff[LRFP_BIT_PACK_SEL] ? pack_voltage
                                         : stack_voltage;
    volt_ok = sel_volt > $signed(fuse_min_ff);
    // Switch failure may bypass the voltage check
    blow_req = permanent_failure && cfg_ff[LRFP_BIT_PF_BLOW] &&
               (volt_ok || (cfg_ff[LRFP_BIT_FET_BYPASS] &&
                (charge_switch_failure || discharge_switch_failure)));
    nxt_fuse = blow_req;
    // Sticky events; set beats a write-one clear in the same cycle
    if (sc_lat_ff && !nxt_sc_lat) begin
      nxt_stat[LRFP_EV_SC_CLR] = 1'b1;
    end
    if (oc_lat_ff && !nxt_oc_lat) begin
      nxt_stat[LRFP_EV_OC_CLR] = 1'b1;
    end
    if (blow_req && !fuse_ff) begin
      nxt_stat[LRFP_EV_FUSE] = 1'b1;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  // Register all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= LRFP_CFG_RESET;
      thr_ff <= LRFP_SOURCES_RESET;
      sc_time_ff <= LRFP_TIME_RESET;
      oc_time_ff <= LRFP_TIME_RESET;
      fuse_min_ff <= LRFP_FUSE_MIN_RESET;
      stat_ff <= '0;
      mask_ff <= '0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      sc_lat_ff <= 1'b0;
      oc_lat_ff <= 1'b0;
      fuse_ff <= 1'b0;
      irq_ff <= 1'b0;
      ld_sync_ff <= 3'h0;
      ld_removed_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      thr_ff <= nxt_thr;
      sc_time_ff <= nxt_sc_time;
      oc_time_ff <= nxt_oc_time;
      fuse_min_ff <= nxt_fuse_min;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      sc_lat_ff <= nxt_sc_lat;
      oc_lat_ff <= nxt_oc_lat;
      fuse_ff <= nxt_fuse;
      irq_ff <= nxt_irq;
      ld_sync_ff <= nxt_ld_sync;
      ld_removed_ff <= nxt_ld_removed;
    end
  end

  // Outputs straight from flops; ready and OKAY are constant
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign short_circuit_latched_fault = sc_lat_ff;
  assign discharge_overcurrent_latched_fault = oc_lat_ff;
  assign fuse_blow = fuse_ff;
  assign irq = irq_ff;

  // Reserved config bits never read back set
  chk_cfg_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff[15:11] == 5'h00)
    else $error("reserved config bits set");
  // Without bit 10, short latch survives when no other route acts
  chk_sc_no_cur: assert property (@(posedge hclk) disable iff (!hresetn)
    sc_lat_ff && !cfg_ff[LRFP_BIT_SC_REC] && !ld_removed_ff && !cmd_sc
    |=> sc_lat_ff)
    else $error("short latch cleared by current while disabled");
  chk_oc_no_cur: assert property (@(posedge hclk) disable iff (!hresetn)
    oc_lat_ff && !cfg_ff[LRFP_BIT_OC_REC] && !ld_removed_ff && !cmd_oc
    |=> oc_lat_ff)
    else $error("overcurrent latch cleared by current while disabled");
  // Host command clears the short latch, load removal the overcurrent latch, next cycle
  chk_sc_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_sc && !short_circuit_discharge |=> !sc_lat_ff)
    else $error("host command did not clear short latch");
  chk_oc_load: assert property (@(posedge hclk) disable iff (!hresetn)
    ld_removed_ff && !overcurrent_discharge |=> !oc_lat_ff)
    else $error("load removal did not clear overcurrent latch");
  // No blow while disabled
  chk_fuse_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_ff[LRFP_BIT_PF_BLOW] |=> !fuse_ff)
    else $error("fuse blow while disabled");
  // Low voltage without bypass blocks the blow
  chk_fuse_volt: assert property (@(posedge hclk) disable iff (!hresetn)
    !volt_ok && !cfg_ff[LRFP_BIT_FET_BYPASS] |=> !fuse_ff)
    else $error("fuse blow below minimum voltage");
  chk_fuse_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
    permanent_failure && cfg_ff[LRFP_BIT_PF_BLOW] &&
    cfg_ff[LRFP_BIT_FET_BYPASS] && charge_switch_failure |=> fuse_ff)
    else $error("switch failure bypass did not blow fuse");
  chk_volt_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff[LRFP_BIT_PACK_SEL] |-> sel_volt == pack_voltage)
    else $error("wrong voltage source for fuse check");
endmodule

/* File: tb/lrfp_top_tb_top.sv */
// Self-checking bench for the fault recovery and fuse policy block
`timescale 1ns/10ps
module lrfp_top_tb_top import lrfp_pkg::*; ;
  logic hclk, hresetn, hsel, hwrite, hready; // Clock, reset, bus control
  logic [31:0] haddr, hwdata, hrdata; // Bus address and data
  logic [1:0] htrans; // Transfer type
  logic [2:0] hsize; // Always a word
  logic hreadyout, hresp; // Slave answer
  logic sc_trip, oc_trip, load_rm; // Fault trips and load pin
  logic signed [15:0] cur, stk, pck; // Current and voltages
  logic pf, csf, dsf; // Failure levels
  logic sc_lat, oc_lat, fuse, irq; // Observed outputs
  int errors, checks_done; // Mismatch and comparison counts
  logic [31:0] rd; // Last word read

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  lrfp_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .short_circuit_discharge(sc_trip),
    .overcurrent_discharge(oc_trip), .load_sense_pin(load_rm),
    .current(cur), .stack_voltage(stk), .pack_voltage(pck),
    .permanent_failure(pf), .charge_switch_failure(csf),
    .discharge_switch_failure(dsf),
    .short_circuit_latched_fault(sc_lat),
    .discharge_overcurrent_latched_fault(oc_lat),
    .fuse_blow(fuse), .irq(irq));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare a bus word
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  // Compare a single output flag
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  // One AHB-Lite single word transfer; read data taken at data phase end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= LRFP_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk); // Address phase held
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk); // Data phase held
    rd = hrdata;
  endtask

  // Read and compare one register
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check32(rd, exp);
  endtask

  // Pulse both trips for one cycle
  task automatic trip_both();
    @(posedge hclk);
    sc_trip <= 1'b1;
    oc_trip <= 1'b1;
    @(posedge hclk);
    sc_trip <= 1'b0;
    oc_trip <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // Reset value, writable bits, unmapped place
  task automatic test_regs();
    check1(hresp, 1'b0);
    check1(hreadyout, 1'b1); // Zero-wait slave
    rdchk(LRFP_ADDR_CFG, 32'h0000_0002);
    rdchk(LRFP_ADDR_SC_TIME, LRFP_TIME_RESET); // Default recovery time
    xfer(1'b1, LRFP_ADDR_CFG, 32'hFFFF_FFFF);
    rdchk(LRFP_ADDR_CFG, 32'h0000_07FF);
    rdchk(8'h40, 32'h0000_0000); // Unmapped reads zero
    xfer(1'b1, LRFP_ADDR_CFG, 32'h0000_0002);
    $display("test_regs done");
  endtask

  // Host clear, sticky status, mask and interrupt
  task automatic test_host();
    trip_both();
    check1(sc_lat, 1'b1);
    check1(oc_lat, 1'b1);
    rdchk(LRFP_ADDR_STATE, 32'h0000_0003);
    xfer(1'b1, LRFP_ADDR_CMD, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    check1(sc_lat, 1'b0);
    check1(oc_lat, 1'b0);
    rdchk(LRFP_ADDR_STATUS, 32'h0000_0003);
    check1(irq, 1'b0); // Masked: no interrupt
    xfer(1'b1, LRFP_ADDR_MASK, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    check1(irq, 1'b1);
    xfer(1'b1, LRFP_ADDR_STATUS, 32'h0000_0001); // Write one clears
    repeat (2) @(posedge hclk);
    check1(irq, 1'b0);
    rdchk(LRFP_ADDR_STATUS, 32'h0000_0002);
    xfer(1'b1, LRFP_ADDR_STATUS, 32'h0000_0002);
    xfer(1'b1, LRFP_ADDR_MASK, 32'h0000_0000);
    $display("test_host done");
  endtask

  // Load removal clears both latches after the pin synchroniser
  task automatic test_load();
    trip_both();
    load_rm <= 1'b1;
    repeat (8) @(posedge hclk);
    check1(sc_lat, 1'b0);
    check1(oc_lat, 1'b0);
    load_rm <= 1'b0;
    repeat (6) @(posedge hclk);
    xfer(1'b1, LRFP_ADDR_STATUS, 32'h0000_0003);
    $display("test_load done");
  endtask

  // Sustained current recovery; recovery time shortened to 8 cycles
  task automatic test_curr();
    xfer(1'b1, LRFP_ADDR_SOURCES, 32'h0020_0010);
    xfer(1'b1, LRFP_ADDR_SC_TIME, 32'h0000_0008);
    xfer(1'b1, LRFP_ADDR_OC_TIME, 32'h0000_0008);
    trip_both();
    cur <= 16'sh0020;
    repeat (20) @(posedge hclk);
    check1(sc_lat, 1'b1);
    check1(oc_lat, 1'b1);
    cur <= 16'sh000F;
    xfer(1'b1, LRFP_ADDR_CFG, 32'h0000_0402);
    cur <= 16'sh0010; // Exactly at the short threshold
    repeat (5) @(posedge hclk);
    cur <= 16'sh000F; // One-cycle dip
    @(posedge hclk);
    cur <= 16'sh0010;
    repeat (6) @(posedge hclk);
    check1(sc_lat, 1'b1);
    repeat (6) @(posedge hclk);
    check1(sc_lat, 1'b0);
    check1(oc_lat, 1'b1);
    xfer(1'b1, LRFP_ADDR_CFG, 32'h0000_0202);
    cur <= 16'sh0020;
    repeat (14) @(posedge hclk);
    check1(oc_lat, 1'b0);
    cur <= 16'sh0000;
    xfer(1'b1, LRFP_ADDR_STATUS, 32'h0000_0003);
    $display("test_curr done");
  endtask

  // One fuse policy case: config, voltages, switch failures, expectation
  task automatic fcase(input logic [15:0] c, input logic signed [15:0] s,
                       input logic signed [15:0] p, input logic cs,
                       input logic ds, input logic e);
    xfer(1'b1, LRFP_ADDR_CFG, {16'h0000, c});
    stk <= s;
    pck <= p;
    csf <= cs;
    dsf <= ds;
    repeat (3) @(posedge hclk);
    check1(fuse, e);
  endtask

  // Fuse decision over enable, source select, threshold and bypass
  task automatic test_fuse();
    xfer(1'b1, LRFP_ADDR_FUSE_MIN, 32'h0000_0064);
    pf <= 1'b1;
    fcase(16'h0002, 16'sd200, 16'sd0, 1'b0, 1'b0, 1'b0);
    fcase(16'h0012, 16'sd100, 16'sd0, 1'b0, 1'b0, 1'b0);
    fcase(16'h0012, 16'sd101, 16'sd0, 1'b0, 1'b0, 1'b1);
    fcase(16'h0092, 16'sd50, 16'sd150, 1'b0, 1'b0, 1'b1);
    fcase(16'h0092, 16'sd150, 16'sd50, 1'b0, 1'b0, 1'b0);
    fcase(16'h0012, 16'sd0, 16'sd0, 1'b1, 1'b0, 1'b0);
    fcase(16'h0112, 16'sd0, 16'sd0, 1'b1, 1'b0, 1'b1);
    fcase(16'h0112, 16'sd0, 16'sd0, 1'b0, 1'b1, 1'b1);
    fcase(16'h0102, 16'sd0, 16'sd0, 1'b0, 1'b1, 1'b0);
    rdchk(LRFP_ADDR_STATUS, 32'h0000_0004); // Fuse event is sticky
    pf <= 1'b0;
    $display("test_fuse done");
  endtask

  // Main sequence: reset for 5 cycles, then the scenarios
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    {sc_trip, oc_trip, load_rm, pf, csf, dsf} = 6'h00;
    cur = 16'sh0000;
    stk = 16'sh0000;
    pck = 16'sh0000;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_host();
    test_load();
    test_curr();
    test_fuse();
    tally_and_finish();
  end

  // Watchdog: the scenarios need about two hundred cycles
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
